// ### src/ple_pkg.sv
package ple_pkg;
    // Bus geometry
    localparam int PADDR_W = 12;
    localparam int PDATA_W = 32;

    // Configuration words per equation, equation stride in bytes and word indices
    localparam int CFG_WORDS     = 3;
    localparam int CFG_STRIDE    = 16;
    localparam logic [1:0] CFG_W_INPUTS = 2'h0;
    localparam logic [1:0] CFG_W_MODE   = 2'h1;
    localparam logic [1:0] CFG_W_DELAY  = 2'h2;

    // Status and control byte addresses
    localparam logic [PADDR_W-1:0] ADDR_CTRL    = 12'h400;
    localparam logic [PADDR_W-1:0] ADDR_DIRECT  = 12'h404;
    localparam logic [PADDR_W-1:0] ADDR_LATCHED = 12'h408;
    localparam logic [PADDR_W-1:0] ADDR_EXT     = 12'h40C;
    localparam logic [PADDR_W-1:0] ADDR_SWEEPS  = 12'h410;

    // Control bits
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_RUN_RST = 1'b1;

    // Signal selector width and field positions
    localparam int SEL_W        = 6;
    localparam int SEL0_LSB     = 0;
    localparam int SEL1_LSB     = 8;
    localparam int SEL2_LSB     = 16;
    localparam int SEL3_LSB     = 24;
    localparam int INV_LSB      = 0;
    localparam int OP_LSB       = 4;
    localparam int RST_SEL_LSB  = 8;
    localparam int RST_INV_BIT  = 16;
    localparam int RISE_LSB     = 0;
    localparam int FALL_LSB     = 16;
    localparam int DLY_W        = 16;

    // Gate operators
    localparam logic [1:0] OP_AND  = 2'h0;
    localparam logic [1:0] OP_OR   = 2'h1;
    localparam logic [1:0] OP_NAND = 2'h2;
    localparam logic [1:0] OP_NOR  = 2'h3;
endpackage

// ### src/ple_cfg_mem.sv
`timescale 1ns/10ps
`default_nettype none
module ple_cfg_mem #(
    parameter int N_ROWS = 8,
    parameter int RW     = 3,
    parameter int WORDS  = 3
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    wr_en,
    input  wire logic [RW-1:0]           wr_row,
    input  wire logic [1:0]              wr_word,
    input  wire logic [31:0]             wr_data,
    input  wire logic [RW-1:0]           rd_a_row,
    input  wire logic [1:0]              rd_a_word,
    output var  logic [31:0]             rd_a_data,
    input  wire logic [RW-1:0]           rd_b_row,
    output var  logic [WORDS*32-1:0]     rd_b_data
);
    typedef struct packed {
        logic [N_ROWS-1:0][WORDS-1:0][31:0] mem;
        logic [31:0]                        rd_a;
        logic [WORDS*32-1:0]                rd_b;
    } ple_mem_s;

    ple_mem_s st;
    ple_mem_s next_st;

    always_comb
    begin
        next_st = st;
        if (wr_en && (32'(wr_word) < WORDS))
        begin
            next_st.mem[wr_row][wr_word] = wr_data;
        end
        // Registered reads
        next_st.rd_a = (32'(rd_a_word) < WORDS) ? st.mem[rd_a_row][rd_a_word] : 32'h0;
        next_st.rd_b = st.mem[rd_b_row];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_a_data = st.rd_a;
    assign rd_b_data = st.rd_b;
endmodule
`default_nettype wire

// ### src/ple_eq_core.sv
`timescale 1ns/10ps
`default_nettype none
module ple_eq_core
    import ple_pkg::*;
(
    input  wire logic [3:0]                in_val,
    input  wire logic [3:0]                in_inv,
    input  wire logic [1:0]                op,
    input  wire logic                      rst_val,
    input  wire logic                      rst_inv,
    input  wire logic [ple_pkg::DLY_W-1:0] rise_delay_time,
    input  wire logic [ple_pkg::DLY_W-1:0] fall_delay_time,
    input  wire logic [ple_pkg::DLY_W-1:0] cnt,
    input  wire logic                      tout,
    input  wire logic                      latch,
    output logic [ple_pkg::DLY_W-1:0]      next_cnt,
    output logic                           next_tout,
    output logic                           next_latch
);
    logic [3:0]       cond;
    logic             gate;
    logic             clr;
    logic [DLY_W-1:0] dly;

    always_comb
    begin
        cond = in_val ^ in_inv;
        unique case (op)
            OP_AND:  gate = &cond;
            OP_OR:   gate = |cond;
            OP_NAND: gate = ~&cond;
            OP_NOR:  gate = ~|cond;
        endcase
        // Hold-off timer, counted in sweeps
        dly = gate ? rise_delay_time : fall_delay_time;
        next_cnt  = '0;
        next_tout = tout;
        if (gate != tout)
        begin
            if ((dly == '0) || (cnt >= dly))
            begin
                next_tout = gate;
            end
            else
            begin
                next_cnt = cnt + 1'b1;
            end
        end
        clr = rst_val ^ rst_inv;
        next_latch = clr ? 1'b0 : (latch | next_tout);
    end
endmodule
`default_nettype wire

// ### src/ple_top.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ple_top
    import ple_pkg::*;
#(
    parameter int N_EQ  = 8,
    parameter int N_EXT = 16
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ple_pkg::PADDR_W-1:0] paddr,
    input  wire logic [ple_pkg::PDATA_W-1:0] pwdata,
    output logic [ple_pkg::PDATA_W-1:0]      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [N_EXT-1:0]            ext_in,
    output logic [N_EQ-1:0]                  direct_out,
    output logic [N_EQ-1:0]                  latched_out,
    output logic [N_EQ-1:0]                  latched_n_out,
    output logic                             sweep_done
);
    localparam int IW    = (N_EQ > 1) ? $clog2(N_EQ) : 1;
    localparam int N_SRC = N_EXT + 3 * N_EQ;
    localparam logic [IW-1:0] LAST_EQ = IW'(N_EQ - 1);

    typedef struct packed {
        logic [N_EXT-1:0]             sync1;
        logic [N_EXT-1:0]             sync2;
        logic [N_EXT-1:0]             ext_snap;
        logic [IW-1:0]                fetch_idx;
        logic [IW-1:0]                eval_idx;
        logic                         eval_vld;
        logic                         run;
        logic [N_EQ-1:0]              direct;
        logic [N_EQ-1:0]              latched;
        logic [N_EQ-1:0]              latched_n;
        logic [N_EQ-1:0][DLY_W-1:0]   cnt;
        logic [31:0]                  sweeps;
        logic                         sweep_done;
        logic                         pready;
        logic                         pslverr;
        logic [31:0]                  prdata;
    } ple_state_s;

    ple_state_s st;
    ple_state_s next_st;

    logic [CFG_WORDS*32-1:0] cfg_row;
    logic [31:0]             cfg_rd;
    logic                    cfg_hit;
    logic                    mem_we;
    logic [IW-1:0]           bus_row;
    logic [1:0]              bus_word;
    logic [N_SRC-1:0]        src;
    logic [3:0]              in_val;
    logic [DLY_W-1:0]        core_cnt;
    logic                    core_tout;
    logic                    core_latch;
    logic                    rst_val;

    function automatic logic pick(input logic [N_SRC-1:0] s, input logic [SEL_W-1:0] sel);
        pick = (32'(sel) < N_SRC) ? s[sel] : 1'b0;
    endfunction

    function automatic logic [31:0] widen_eq(input logic [N_EQ-1:0] v);
        widen_eq = 32'(v);
    endfunction

    // Bus address decode
    always_comb
    begin
        bus_row  = paddr[IW+3:4];
        bus_word = paddr[3:2];
        cfg_hit  = (paddr[PADDR_W-1:IW+4] == '0)
                   && (32'(paddr[PADDR_W-1:4]) < N_EQ)
                   && (32'(bus_word) < CFG_WORDS);
        mem_we   = psel && penable && st.pready && pwrite && cfg_hit;
    end

    ple_cfg_mem #(
        .N_ROWS (N_EQ),
        .RW     (IW),
        .WORDS  (CFG_WORDS)
    ) i_ple_cfg_mem (
        .clk       (clk),
        .reset     (reset),
        .wr_en     (mem_we),
        .wr_row    (bus_row),
        .wr_word   (bus_word),
        .wr_data   (pwdata),
        .rd_a_row  (bus_row),
        .rd_a_word (bus_word),
        .rd_a_data (cfg_rd),
        .rd_b_row  (st.fetch_idx),
        .rd_b_data (cfg_row)
    );

    // Selectable signal list: inputs, then direct, latched and inverted latched
    always_comb
    begin
        src = {st.latched_n, st.latched, st.direct, st.ext_snap};
        in_val[0] = pick(src, cfg_row[SEL0_LSB +: SEL_W]);
        in_val[1] = pick(src, cfg_row[SEL1_LSB +: SEL_W]);
        in_val[2] = pick(src, cfg_row[SEL2_LSB +: SEL_W]);
        in_val[3] = pick(src, cfg_row[SEL3_LSB +: SEL_W]);
        rst_val   = pick(src, cfg_row[32 + RST_SEL_LSB +: SEL_W]);
    end

    ple_eq_core i_ple_eq_core (
        .in_val          (in_val),
        .in_inv          (cfg_row[32 + INV_LSB +: 4]),
        .op              (cfg_row[32 + OP_LSB +: 2]),
        .rst_val         (rst_val),
        .rst_inv         (cfg_row[32 + RST_INV_BIT]),
        .rise_delay_time (cfg_row[64 + RISE_LSB +: DLY_W]),
        .fall_delay_time (cfg_row[64 + FALL_LSB +: DLY_W]),
        .cnt             (st.cnt[st.eval_idx]),
        .tout            (st.direct[st.eval_idx]),
        .latch           (st.latched[st.eval_idx]),
        .next_cnt        (core_cnt),
        .next_tout       (core_tout),
        .next_latch      (core_latch)
    );

    always_comb
    begin
        next_st = st;
        next_st.sync1      = ext_in;
        next_st.sync2      = st.sync1;
        next_st.sweep_done = 1'b0;

        // Fetch stage walks the terms upward and wraps
        next_st.eval_vld = st.run;
        next_st.eval_idx = st.fetch_idx;
        if (st.run)
        begin
            next_st.fetch_idx = (st.fetch_idx == LAST_EQ) ? '0 : st.fetch_idx + 1'b1;
        end

        // Result written in place: later terms see it now, earlier ones next sweep
        if (st.eval_vld)
        begin
            next_st.cnt[st.eval_idx]       = core_cnt;
            next_st.direct[st.eval_idx]    = core_tout;
            next_st.latched[st.eval_idx]   = core_latch;
            next_st.latched_n[st.eval_idx] = ~core_latch;
            if (st.eval_idx == LAST_EQ)
            begin
                next_st.ext_snap   = st.sync2;
                next_st.sweeps     = st.sweeps + 32'h1;
                next_st.sweep_done = 1'b1;
            end
        end

        // Bus slave: answer one cycle into the access phase
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && penable && !st.pready)
        begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0;
            if (cfg_hit)
            begin
                next_st.prdata = pwrite ? 32'h0 : cfg_rd;
            end
            else
            begin
                unique case (paddr)
                    ADDR_CTRL:    next_st.prdata = 32'(st.run);
                    ADDR_DIRECT:  next_st.prdata = widen_eq(st.direct);
                    ADDR_LATCHED: next_st.prdata = widen_eq(st.latched);
                    ADDR_EXT:     next_st.prdata = 32'(st.ext_snap);
                    ADDR_SWEEPS:  next_st.prdata = st.sweeps;
                    default:      next_st.pslverr = 1'b1;
                endcase
                if (pwrite && (paddr != ADDR_CTRL))
                begin
                    next_st.pslverr = 1'b1;
                end
            end
        end

        // Control write takes effect at the completing edge
        if (psel && penable && st.pready && pwrite && (paddr == ADDR_CTRL))
        begin
            next_st.run = pwdata[CTRL_RUN_BIT];
            if (pwdata[CTRL_CLEAR_BIT])
            begin
                next_st.latched   = '0;
                next_st.latched_n = '1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st           <= '0;
            st.run       <= CTRL_RUN_RST;
            st.latched_n <= '1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata        = st.prdata;
    assign pready        = st.pready;
    assign pslverr       = st.pslverr;
    assign direct_out    = st.direct;
    assign latched_out   = st.latched;
    assign latched_n_out = st.latched_n;
    assign sweep_done    = st.sweep_done;
endmodule
`default_nettype wire

// ### tb/ple_sig_src.sv
`timescale 1ns/10ps
`default_nettype none
// Protection signal source, lines change just after a clock edge
module ple_sig_src #(
    parameter int N = 16
) (
    input  wire logic         clk,
    input  wire logic [N-1:0] want,
    output logic      [N-1:0] ext_in
);
    always_ff @(posedge clk)
    begin
        ext_in <= want;
    end
endmodule
`default_nettype wire

// ### tb/ple_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ple_top_chk #(
    parameter int N_EQ  = 8,
    parameter int N_EXT = 16
) (
    input wire logic            clk,
    input wire logic            reset,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic [N_EQ-1:0] direct_out,
    input wire logic [N_EQ-1:0] latched_out,
    input wire logic [N_EQ-1:0] latched_n_out,
    input wire logic            sweep_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_in_access: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside answer");
    a_latch_comp: assert property (latched_n_out == ~latched_out)
        else $error("inverted latch output wrong");
    a_set_by_direct: assert property ((latched_out & ~$past(latched_out) & ~direct_out) == '0)
        else $error("latch set without direct output");
    a_one_term_step: assert property ($onehot0(direct_out ^ $past(direct_out)))
        else $error("several terms changed in one cycle");
    a_sweep_period: assert property (sweep_done |=> !sweep_done [*7] ##1 sweep_done)
        else $error("sweep length wrong");
    a_reset_state: assert property (@(posedge clk) disable iff (1'b0) reset |=>
        direct_out == '0 && latched_out == '0 && latched_n_out == '1 && !pready && !sweep_done)
        else $error("reset state wrong");

    c_sweep: cover property (sweep_done);
    c_refused: cover property (pready && pslverr);
    c_reset_wins: cover property ($fell(latched_out[N_EQ-1]) && direct_out[N_EQ-1]);
endmodule

bind ple_top ple_top_chk #(.N_EQ(N_EQ), .N_EXT(N_EXT)) i_ple_top_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .direct_out(direct_out), .latched_out(latched_out),
    .latched_n_out(latched_n_out), .sweep_done(sweep_done));
`default_nettype wire

// ### tb/ple_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ple_tb_top;
    import ple_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] want = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] ext_in;
    logic [7:0]  direct_out;
    logic [7:0]  latched_out;
    logic [7:0]  latched_n_out;
    logic        sweep_done;
    int          n_mismatch = 0;
    int          n_compared = 0;

    always #25 clk = ~clk;

    ple_top #(.N_EQ(8), .N_EXT(16)) i_ple_top (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_in(ext_in),
        .direct_out(direct_out), .latched_out(latched_out),
        .latched_n_out(latched_n_out), .sweep_done(sweep_done));
    ple_sig_src #(.N(16)) i_ple_sig_src (.clk(clk), .want(want), .ext_in(ext_in));

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] xq, input logic xe);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        check("pready", 32'(pready), 32'h1);
        check("pslverr", 32'(pslverr), 32'(xe));
        if (!wr && !xe)
        begin
            check("prdata", prdata, xq);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sweeps(input int n);
        int k;
        repeat (n)
        begin
            k = 0;
            do
            begin
                @(posedge clk);
                k++;
            end
            while (sweep_done !== 1'b1 && k < 40);
            check("sweep_done", 32'(sweep_done), 32'h1);
        end
    endtask

    function automatic logic [31:0] all4(input logic [5:0] s);
        return {4{2'h0, s}};
    endfunction

    function automatic logic [31:0] mode(input logic ri, input logic [5:0] rs,
                                         input logic [1:0] op, input logic [3:0] inv);
        return {15'h0000, ri, 2'h0, rs, 2'h0, op, inv};
    endfunction

    task automatic cfg(input int e, input logic [31:0] w0, input logic [31:0] w1,
                       input logic [31:0] w2);
        logic [11:0] b;
        b = 12'(CFG_STRIDE * e);
        xfer(1'b1, b, w0, 32'h0, 1'b0);
        xfer(1'b1, b + 12'h004, w1, 32'h0, 1'b0);
        xfer(1'b1, b + 12'h008, w2, 32'h0, 1'b0);
    endtask

    task automatic t_regs();
        xfer(1'b0, ADDR_CTRL, 32'h0, 32'h00000001, 1'b0);
        xfer(1'b0, 12'h020, 32'h0, 32'h00000000, 1'b0);
        xfer(1'b1, 12'h014, 32'h00010A3F, 32'h0, 1'b0);
        xfer(1'b0, 12'h014, 32'h0, 32'h00010A3F, 1'b0);
        xfer(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, 12'h800, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, ADDR_DIRECT, 32'h000000FF, 32'h0, 1'b1);
    endtask

    task automatic t_gates();
        logic [3:0] pats [3];
        logic [3:0] x;
        logic       r;
        pats = '{4'h5, 4'hA, 4'h3};
        for (int op = 0; op < 4; op++)
        begin
            cfg(5, {2'h0, 6'h07, 2'h0, 6'h06, 2'h0, 6'h05, 2'h0, 6'h04},
                mode(1'b0, 6'h00, 2'(op), 4'h5), 32'h0);
            for (int i = 0; i < 3; i++)
            begin
                want[7:4] <= pats[i];
                sweeps(3);
                x = pats[i] ^ 4'h5;
                r = (2'(op) == OP_OR || 2'(op) == OP_NOR) ? |x : &x;
                r = r ^ (2'(op) == OP_NAND || 2'(op) == OP_NOR);
                check("gate", 32'(direct_out[5]), 32'(r));
            end
        end
    endtask

    task automatic t_cascade();
        int k;
        cfg(3, all4(6'h02), mode(1'b0, 6'h00, OP_OR, 4'h0), 32'h0);
        cfg(2, all4(6'h13), mode(1'b0, 6'h00, OP_OR, 4'h0), 32'h0);
        cfg(4, all4(6'h13), mode(1'b0, 6'h00, OP_OR, 4'h0), 32'h0);
        sweeps(2);
        want[2] <= 1'b1;
        k = 0;
        do
        begin
            sweeps(1);
            k++;
        end
        while (direct_out[3] !== 1'b1 && k < 8);
        check("same sweep", 32'(direct_out[4]), 32'h1);
        check("prior sweep", 32'(direct_out[2]), 32'h0);
        sweeps(1);
        check("next sweep", 32'(direct_out[2]), 32'h1);
        xfer(1'b0, ADDR_EXT, 32'h0, 32'h00000034, 1'b0);
        xfer(1'b0, ADDR_DIRECT, 32'h0, 32'h0000001C, 1'b0);
        xfer(1'b0, ADDR_LATCHED, 32'h0, 32'h0000003C, 1'b0);
    endtask

    task automatic t_delay();
        int c;
        cfg(1, all4(6'h08), mode(1'b0, 6'h00, OP_OR, 4'h0), 32'h0);
        cfg(6, all4(6'h08), mode(1'b0, 6'h00, OP_OR, 4'h0), {16'h0002, 16'h0003});
        for (int v = 1; v >= 0; v--)
        begin
            c = 0;
            want[8] <= 1'(v);
            repeat (8)
            begin
                sweeps(1);
                c = c + ((direct_out[1] !== direct_out[6]) ? 1 : 0);
            end
            check("lag sweeps", 32'(c), (v == 1) ? 32'h3 : 32'h2);
            check("zero delay", 32'(direct_out[1]), 32'(v));
        end
    endtask

    task automatic t_latch();
        logic [5:0] steps [8];
        steps = '{6'h09, 6'h16, 6'h02, 6'h1D, 6'h16, 6'h35, 6'h3E, 6'h2A};
        cfg(7, all4(6'h09), mode(1'b0, 6'h0A, OP_OR, 4'h0), 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, 12'h074, mode(steps[i][5], 6'h0A, OP_OR, 4'h0), 32'h0, 1'b0);
            want[10:9] <= {steps[i][3], steps[i][4]};
            sweeps(3);
            check("latch", {29'h0, direct_out[7], latched_out[7], latched_n_out[7]},
                  {29'h0, steps[i][2:0]});
        end
        xfer(1'b1, ADDR_CTRL, 32'h00000003, 32'h0, 1'b0);
        sweeps(1);
        check("clear all", 32'(latched_out[7]), 32'h0);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_gates();
        t_cascade();
        t_delay();
        t_latch();
        give_verdict();
    end
endmodule
`default_nettype wire
